//--- hw/scp_commit_gate.sv
/*
  one direction's commitment gate: tracks outstanding split request size
  in ADQs against the programmed limit and grants or holds each request.
  assumes requests stay offered until granted and done never exceeds
  what was granted.
*/
module scp_commit_gate (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // limit from the register bank
  input  wire logic [15:0]      limit,
  // request and completion
  input  wire scp_pkg::scp_req_t  req,
  input  wire scp_pkg::scp_done_t done,
  // state out
  output scp_pkg::scp_dir_t       state
);
  import scp_pkg::*;

  scp_dir_t    st;
  scp_dir_t    next_st;
  logic [16:0] base;
  logic [17:0] want;

  always_comb begin
    next_st       = st;
    next_st.limit = limit;
    base          = st.outstanding;
    if (done.valid) begin
      base = (base >= {1'b0, done.size_adq}) ?
             17'(base - {1'b0, done.size_adq}) : 17'h00000;
    end
    want          = {1'b0, base} + {2'b00, req.size_adq};
    next_st.grant = 1'b0;
    next_st.held  = 1'b0;
    if (req.valid && !st.grant) begin
      if (limit == SCP_LIMIT_UNBOUNDED) begin
        next_st.grant = 1'b1;
      end else if (want <= {2'b00, limit}) begin
        next_st.grant = 1'b1;
      end else begin
        next_st.held  = 1'b1;
      end
    end
    if (next_st.grant) begin
      base = (want > 18'h1FFFF) ? 17'h1FFFF : want[16:0];
    end
    next_st.outstanding = base;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '{limit: SCP_LIMIT_RESET, outstanding: 17'h00000,
              grant: 1'b0, held: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign state = st;
endmodule

//--- hw/scp_pkg.sv
/*
  package of the split commitment and power capability register bank:
  register offsets, field layouts, reset values and carrier structs.
  assumes a single 100 MHz clock domain and AHB-Lite register access.
*/
// How it works
// - upstream capability field 15:0 reads the fixed value 0010h (16 ADQs).
// - downstream capability field 15:0 reads the fixed value 0010h.
// - each commitment limit 31:16 is freely writable and resets to 0010h.
// - a limit of FFFFh lets every split request through in that direction.
// - commitment is the running sum of outstanding split sizes in ADQs.
// - a request that would exceed the limit is held and sets sticky bit 21.
// - the power capability identifier byte 7:0 reads 01h.
// - the next capability link byte 15:8 reads A8h.
// - the version field 18:16 reads 010.
// - bit 19 reads zero, no clock needed for the power event output.
// - bit 21 reads zero, no special initialisation needed.
// - bits 25 and 26 read zero, D1 and D2 not supported.
// - bits 31:27 read 11001, power events from D3 cold, D3 hot and D0.
package scp_pkg;

  localparam logic [7:0]  SCP_OFS_UP_COMMIT   = 8'h88;
  localparam logic [7:0]  SCP_OFS_DN_COMMIT   = 8'h8C;
  localparam logic [7:0]  SCP_OFS_POWER_CAP   = 8'h90;
  // own status register: bit 21 = split request delayed (write 1 clears)
  localparam logic [7:0]  SCP_OFS_SPLIT_STAT  = 8'hA0;

  localparam logic [15:0] SCP_SPLIT_CAP       = 16'h0010;
  localparam logic [15:0] SCP_LIMIT_RESET     = 16'h0010;
  localparam logic [15:0] SCP_LIMIT_UNBOUNDED = 16'hFFFF;
  localparam int          SCP_LIMIT_LSB       = 16;
  localparam int          SCP_DELAYED_BIT     = 21;
  localparam int          SCP_DIR_UP          = 0;
  localparam int          SCP_DIR_DN          = 1;

  localparam logic [7:0]  SCP_PM_ID           = 8'h01;
  localparam logic [7:0]  SCP_PM_NEXT         = 8'hA8;
  localparam logic [2:0]  SCP_PM_VERSION      = 3'h2;
  localparam logic [0:0]  SCP_PM_CLOCK        = 1'h0;
  localparam logic [0:0]  SCP_PM_DSI          = 1'h0;
  localparam logic [2:0]  SCP_PM_AUX_CURRENT  = 3'h1;
  localparam logic [0:0]  SCP_PM_D1           = 1'h0;
  localparam logic [0:0]  SCP_PM_D2           = 1'h0;
  localparam logic [4:0]  SCP_PM_EVENT_SUP    = 5'h19;

  localparam logic [1:0]  SCP_HTRANS_NONSEQ   = 2'h2;
  localparam logic [2:0]  SCP_HSIZE_WORD      = 3'h2;

  // split request offered by one direction's forwarding engine
  typedef struct packed {
    logic        valid;
    logic [15:0] size_adq;
  } scp_req_t;

  // completion of an outstanding split sequence
  typedef struct packed {
    logic        valid;
    logic [15:0] size_adq;
  } scp_done_t;

  // per-direction commitment state
  typedef struct packed {
    logic [15:0] limit;
    logic [16:0] outstanding;
    logic        grant;
    logic        held;
  } scp_dir_t;

endpackage

//--- hw/scp_regs.sv
/*
  split commitment limit and power management capability register bank
  with an AHB-Lite slave port and two commitment gates.
  assumes a single clock, single word transfers and one slave on the bus.
*/
module scp_regs (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [7:0]        haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // upstream split requests
  input  wire scp_pkg::scp_req_t  up_req,
  input  wire scp_pkg::scp_done_t up_done,
  output logic                   up_grant,
  output logic                   up_held,
  // downstream split requests
  input  wire scp_pkg::scp_req_t  dn_req,
  input  wire scp_pkg::scp_done_t dn_done,
  output logic                   dn_grant,
  output logic                   dn_held,
  // split request delayed status
  output logic                   split_delayed
);
  import scp_pkg::*;

  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [15:0] up_limit;
    logic [15:0] dn_limit;
    logic        delayed;
    logic [31:0] rdata;
  } scp_state_t;

  scp_state_t s;
  scp_state_t next_s;
  scp_dir_t   gate_st [2];
  scp_req_t   reqs    [2];
  scp_done_t  dones   [2];
  logic [15:0] limits [2];
  logic       take;
  logic       clr_hit;
  logic [31:0] pm_word;

  assign reqs[SCP_DIR_UP]   = up_req;
  assign reqs[SCP_DIR_DN]   = dn_req;
  assign dones[SCP_DIR_UP]  = up_done;
  assign dones[SCP_DIR_DN]  = dn_done;
  assign limits[SCP_DIR_UP] = s.up_limit;
  assign limits[SCP_DIR_DN] = s.dn_limit;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dir
      scp_commit_gate u_gate (
        .mclk  (mclk),
        .rst   (rst),
        .limit (limits[gi]),
        .req   (reqs[gi]),
        .done  (dones[gi]),
        .state (gate_st[gi])
      );
    end
  endgenerate

  // fixed power management capability word
  assign pm_word = {SCP_PM_EVENT_SUP,
                    SCP_PM_D2,
                    SCP_PM_D1,
                    SCP_PM_AUX_CURRENT,
                    SCP_PM_DSI,
                    1'b0,
                    SCP_PM_CLOCK,
                    SCP_PM_VERSION,
                    SCP_PM_NEXT,
                    SCP_PM_ID};

  assign take = hsel && hready && htrans[1];

  always_comb begin
    next_s   = s;
    clr_hit  = 1'b0;
    // data phase of a write committed last cycle
    if (s.wr_pend) begin
      next_s.wr_pend = 1'b0;
      case (s.wr_addr)
        SCP_OFS_UP_COMMIT: begin
          next_s.up_limit = hwdata[31:16];
        end
        SCP_OFS_DN_COMMIT: begin
          next_s.dn_limit = hwdata[31:16];
        end
        SCP_OFS_SPLIT_STAT: begin
          clr_hit = hwdata[SCP_DELAYED_BIT];
        end
        default: begin
          // capability fields and unmapped space drop the write
          next_s.wr_pend = 1'b0;
        end
      endcase
    end
    // sticky: a new hold wins over a clear in the same cycle
    if (clr_hit) begin
      next_s.delayed = 1'b0;
    end
    if (gate_st[SCP_DIR_UP].held || gate_st[SCP_DIR_DN].held) begin
      next_s.delayed = 1'b1;
    end
    if (take) begin
      if (hwrite) begin
        next_s.wr_pend = 1'b1;
        next_s.wr_addr = haddr;
      end else begin
        case (haddr)
          SCP_OFS_UP_COMMIT: begin
            next_s.rdata = {s.up_limit, SCP_SPLIT_CAP};
          end
          SCP_OFS_DN_COMMIT: begin
            next_s.rdata = {s.dn_limit, SCP_SPLIT_CAP};
          end
          SCP_OFS_POWER_CAP: begin
            next_s.rdata = pm_word;
          end
          SCP_OFS_SPLIT_STAT: begin
            next_s.rdata = 32'h00000000;
            next_s.rdata[SCP_DELAYED_BIT] = s.delayed;
          end
          default: begin
            next_s.rdata = 32'h00000000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '{wr_pend: 1'b0, wr_addr: 8'h00,
             up_limit: SCP_LIMIT_RESET, dn_limit: SCP_LIMIT_RESET,
             delayed: 1'b0, rdata: 32'h00000000};
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      s         <= next_s;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata        = s.rdata;
  assign split_delayed = s.delayed;
  assign up_grant      = gate_st[SCP_DIR_UP].grant;
  assign up_held       = gate_st[SCP_DIR_UP].held;
  assign dn_grant      = gate_st[SCP_DIR_DN].grant;
  assign dn_held       = gate_st[SCP_DIR_DN].held;
endmodule

//--- test/scp_regs_props.sv
/*
  checker for the scp_regs bus answer and split request gates.
  assumes it is bound to scp_regs and sees only that module's ports.
*/
module scp_regs_props (
  // clock and reset
  input wire logic               mclk,
  input wire logic               rst,
  // bus
  input wire logic               hsel,
  input wire logic [7:0]         haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [2:0]         hsize,
  input wire logic               hready,
  input wire logic [31:0]        hwdata,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  // split gates
  input wire scp_pkg::scp_req_t  up_req,
  input wire scp_pkg::scp_done_t up_done,
  input wire logic               up_grant,
  input wire logic               up_held,
  input wire scp_pkg::scp_req_t  dn_req,
  input wire scp_pkg::scp_done_t dn_done,
  input wire logic               dn_grant,
  input wire logic               dn_held,
  input wire logic               split_delayed
);
  timeunit 1ns;
  timeprecision 1ns;
  import scp_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_bus_okay :
    assert property (hresp == 1'h0 && hreadyout == 1'h1)
    else $error("bus answer not ready or not okay");
  a_pm_word :
    assert property (hsel && hready && htrans[1] && !hwrite &&
      haddr == 8'h90 |=> hrdata == 32'hC842A801)
    else $error("power capability word wrong");
  a_cap_fixed :
    assert property (hsel && hready && htrans[1] && !hwrite &&
      (haddr == 8'h88 || haddr == 8'h8C) |=> hrdata[15:0] == 16'h0010)
    else $error("split capability field wrong");
  a_up_pulse :
    assert property (up_grant |=> !up_grant)
    else $error("upstream grant longer than one cycle");
  a_up_cause :
    assert property (up_grant || up_held |-> $past(up_req.valid))
    else $error("upstream answer without request");
  a_dn_cause :
    assert property (dn_grant || dn_held |-> $past(dn_req.valid))
    else $error("downstream answer without request");
  a_grant_excl :
    assert property (!(up_grant && up_held) && !(dn_grant && dn_held))
    else $error("request both granted and held");
  a_held_flag :
    assert property (up_held || dn_held |-> ##[0:1] split_delayed)
    else $error("held request did not set delayed flag");
  a_flag_cause :
    assert property ($rose(split_delayed) |->
      up_held || dn_held || $past(up_held || dn_held))
    else $error("delayed flag set without a hold");
endmodule

//--- test/scp_regs_tb_top.sv
/*
  self-checking bench for scp_regs: register access over ahb-lite and
  split request gating. assumes the package and design under hw/.
*/
module scp_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import scp_pkg::*;
  logic        mclk          = 1'h0;
  logic        rst           = 1'h1;
  logic        hsel          = 1'h0;
  logic        hwrite        = 1'h0;
  logic [7:0]  haddr         = 8'h0;
  logic [1:0]  htrans        = 2'h0;
  logic [2:0]  hsize         = SCP_HSIZE_WORD;
  logic [31:0] hwdata        = 32'h0;
  scp_req_t    up_req        = '0;
  scp_req_t    dn_req        = '0;
  scp_done_t   up_done       = '0;
  scp_done_t   dn_done       = '0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, up_grant, up_held;
  logic        dn_grant, dn_held, split_delayed;
  int          n_fail        = 0;
  int          num_checks    = 0;
  always #5 mclk = ~mclk;
  scp_regs uut (
    .mclk          (mclk),
    .rst           (rst),
    .hsel          (hsel),
    .haddr         (haddr),
    .htrans        (htrans),
    .hwrite        (hwrite),
    .hsize         (hsize),
    .hready        (hreadyout),
    .hwdata        (hwdata),
    .hrdata        (hrdata),
    .hreadyout     (hreadyout),
    .hresp         (hresp),
    .up_req        (up_req),
    .up_done       (up_done),
    .up_grant      (up_grant),
    .up_held       (up_held),
    .dn_req        (dn_req),
    .dn_done       (dn_done),
    .dn_grant      (dn_grant),
    .dn_held       (dn_held),
    .split_delayed (split_delayed)
  );
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= SCP_HTRANS_NONSEQ;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input string nm);
    logic [31:0] q;
    xfer(1'h0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'h1, a, d, q);
  endtask
  // offer one split request, expect grant or hold, then withdraw it
  task automatic offer(input logic dn, input logic [15:0] sz,
                       input logic exp_g, input string nm);
    logic g, h;
    g = 1'h0;
    h = 1'h0;
    if (dn) dn_req <= '{1'h1, sz};
    else up_req <= '{1'h1, sz};
    for (int i = 0; i < 4 && !(g === 1'h1 || h === 1'h1); i++) begin
      @(posedge mclk);
      g = dn ? dn_grant : up_grant;
      h = dn ? dn_held : up_held;
    end
    up_req <= '0;
    dn_req <= '0;
    @(posedge mclk);
    chk(nm, {30'h0, g, h}, {30'h0, exp_g, !exp_g});
  endtask
  task automatic retire(input logic dn, input logic [15:0] sz);
    if (dn) dn_done <= '{1'h1, sz};
    else up_done <= '{1'h1, sz};
    @(posedge mclk);
    up_done <= '0;
    dn_done <= '0;
    @(posedge mclk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    rd(8'h88, 32'h00100010, "up reset");
    rd(8'h8C, 32'h00100010, "dn reset");
    rd(8'h90, 32'hC842A801, "power cap");
    rd(8'hA0, 32'h0, "status reset");
    $display("test reset values done");
    wr(8'h88, 32'hFFFF1234);
    rd(8'h88, 32'hFFFF0010, "up limit");
    wr(8'h8C, 32'h0003FFFF);
    rd(8'h8C, 32'h00030010, "dn limit");
    wr(8'h90, 32'h0);
    rd(8'h90, 32'hC842A801, "power cap kept");
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0, "unmapped");
    $display("test register writes done");
    offer(1'h0, 16'h8000, 1'h1, "up big");
    offer(1'h0, 16'hFFFF, 1'h1, "up bigger");
    offer(1'h1, 16'h0002, 1'h1, "dn first");
    offer(1'h1, 16'h0002, 1'h0, "dn over");
    chk("delayed", {31'h0, split_delayed}, 32'h1);
    rd(8'hA0, 32'h00200000, "status set");
    retire(1'h1, 16'h0002);
    offer(1'h1, 16'h0002, 1'h1, "dn after done");
    offer(1'h1, 16'h0001, 1'h1, "dn at limit");
    wr(8'hA0, 32'h00200000);
    rd(8'hA0, 32'h0, "status clear");
    $display("test split gating done");
    report_and_stop();
  end
  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end
endmodule
bind scp_regs scp_regs_props u_props (.*);
